/* design/config_memory_scrub_controller.sv */
// Functional notes
// - replay from byte zero, stop after frame data
// - bytes sent unaltered, sequential reads only
// - abort after each scrub, optional leading abort
// - counter makes addresses, decode drives controls
// - port gets bytes, wide memory regrouped
// - address from counter, 18 bits for byte-wide memory, one less per doubling of width
// - port clock at most 50 MHz, divided
// - decode memory enables, select and write
// - memory output disabled during abort
// - select and write decoded separately
// - load state all low, per-size length
// - abort four cycles, only select low
// - disable one cycle, all controls high
// - one byte per port clock cycle
// - optional interval counter drives enable, clear
// - abort holds select low, write high, clocked
`timescale 1ns/1ps
`default_nettype none
`include "scrub_map.svh"

module config_memory_scrub_controller #(
  parameter int CNT_W = `SCRUB_CNT_W_MIN,
  parameter int MEM_W = `SCRUB_MEM_W,
  parameter int SYS_MHZ = `SCRUB_SYS_CLK_MHZ,
  parameter int DIV_LOG2 = ($clog2((SYS_MHZ + `SCRUB_CFG_CLK_MAX_MHZ - 1)
    / `SCRUB_CFG_CLK_MAX_MHZ) < 1) ? 1 :
    $clog2((SYS_MHZ + `SCRUB_CFG_CLK_MAX_MHZ - 1) / `SCRUB_CFG_CLK_MAX_MHZ),
  parameter logic [CNT_W-1:0] LOAD_BYTES = CNT_W'(`SCRUB_LOAD_BYTES_SMALL),
  parameter int TW = 32,
  parameter logic [TW-1:0] INTERVAL = TW'(`SCRUB_INTERVAL_CYCLES),
  parameter int ADDR_W = CNT_W - $clog2(MEM_W / `SCRUB_PORT_W)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scrub_ce,
  input wire logic scrub_clear,
  input wire logic auto_interval,
  input wire logic lead_abort,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [MEM_W-1:0] mem_data,
  output logic mem_out_en_n,
  output logic mem_chip_en_n,
  output logic cfg_port_select_n,
  output logic cfg_port_write_n,
  output logic cfg_clock,
  output logic [`SCRUB_PORT_W-1:0] cfg_data,
  input wire logic cfg_busy,
  output var scrub_pkg::scrub_state_type scrub_state,
  output logic scrub_done
);
  import scrub_pkg::*;

  localparam int BPW = MEM_W / `SCRUB_PORT_W;
  localparam int PW = `SCRUB_PORT_W;
  localparam logic [DIV_LOG2-1:0] PH_LAST = '1;
  localparam logic [CNT_W-1:0] ABORT_N = CNT_W'(`SCRUB_ABORT_CYCLES);
  localparam logic [CNT_W-1:0] DIS_N = CNT_W'(`SCRUB_DISABLE_CYCLES);

  scrub_state_type state_r, state_nxt;
  logic [DIV_LOG2-1:0] phase_r, phase_nxt;
  logic [CNT_W-1:0] per_r, per_nxt;
  logic [CNT_W-1:0] fetch_r, fetch_nxt;
  logic live_r, live_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [PW-1:0] data_r, data_nxt;
  logic clk_r, clk_nxt;
  logic oe_n_r, oe_n_nxt;
  logic ce_n_r, ce_n_nxt;
  logic cs_n_r, cs_n_nxt;
  logic wr_n_r, wr_n_nxt;
  logic done_r, done_nxt;

  logic tmr_ce, tmr_clear;
  logic ce_eff, clear_eff;
  logic push, pop, buf_clr;
  logic in_ready, out_valid;
  logic [PW-1:0] out_byte, mem_byte;
  logic fetch_more;
  int lane;

  // fixed-interval scrubbing replaces host pacing when selected
  scrub_interval_timer #(
    .TW(TW),
    .INTERVAL(INTERVAL)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(auto_interval),
    .scrub_ce(tmr_ce),
    .scrub_clear(tmr_clear)
  );

  // one source paces the counter: host or interval timer
  always_comb begin
    ce_eff = auto_interval ? tmr_ce : scrub_ce;
    clear_eff = auto_interval ? tmr_clear : scrub_clear;
  end

  // wide memory words split high byte first; sequential, no edits
  always_comb begin
    lane = int'(fetch_r % CNT_W'(BPW));
    mem_byte = PW'(mem_data >> (PW * (BPW - 1 - lane)));
  end

  // two entries absorb a port stall so no fetched byte is lost
  scrub_byte_buffer #(
    .W(PW),
    .DEPTH(2)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(buf_clr),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(mem_byte),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(out_byte)
  );

  // period engine, fetch side and state sequencing
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    per_nxt = per_r;
    fetch_nxt = fetch_r;
    live_nxt = live_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    done_nxt = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    buf_clr = 1'b0;
    fetch_more = (fetch_r < LOAD_BYTES);
    if (clear_eff) begin
      // synchronous restart; the next scrub replays from byte zero
      state_nxt = st_idle;
      phase_nxt = '0;
      per_nxt = '0;
      fetch_nxt = '0;
      live_nxt = 1'b0;
      addr_nxt = '0;
      buf_clr = 1'b1;
    end else if (ce_eff) begin
      unique case (state_r)
        st_idle: begin
          state_nxt = lead_abort ? st_pre_abort : st_load;
          phase_nxt = '0;
          per_nxt = '0;
          live_nxt = 1'b0;
        end
        st_hold: begin
          // stays put until a clear re-arms it
          state_nxt = st_hold;
        end
        default: begin
          phase_nxt = phase_r + DIV_LOG2'(1);
          // phase_r divides the clock; per_r counts bytes and cycles separately
          if (phase_r == '0) begin
            if (state_r == st_load) begin
              // a port clock is issued only for a byte on the pins
              live_nxt = out_valid && !cfg_busy;
              pop = live_nxt;
              if (live_nxt) begin
                data_nxt = out_byte;
              end
            end else begin
              live_nxt = 1'b1;
            end
          end
          if (phase_r == PH_LAST && live_r) begin
            per_nxt = per_r + CNT_W'(1);
            unique case (state_r)
              st_pre_abort: begin
                if (per_r == ABORT_N - CNT_W'(1)) begin
                  state_nxt = st_load;
                  per_nxt = '0;
                end
              end
              st_load: begin
                if (per_r == LOAD_BYTES - CNT_W'(1)) begin
                  state_nxt = st_abort;
                  per_nxt = '0;
                  buf_clr = 1'b1;
                end
              end
              st_abort: begin
                if (per_r == ABORT_N - CNT_W'(1)) begin
                  state_nxt = st_disable;
                  per_nxt = '0;
                end
              end
              st_disable: begin
                if (per_r == DIS_N - CNT_W'(1)) begin
                  state_nxt = st_hold;
                  per_nxt = '0;
                  done_nxt = 1'b1;
                end
              end
              default: begin
                per_nxt = per_r;
              end
            endcase
          end
          if (phase_r == PH_LAST && !live_r && state_r == st_load) begin
            live_nxt = 1'b0;
          end
          // fetch runs ahead of the port; buffer full stalls it
          if (state_r == st_load && fetch_more) begin
            if (phase_r == '0) begin
              addr_nxt = ADDR_W'(fetch_r / CNT_W'(BPW));
            end
            if (phase_r == PH_LAST) begin
              push = 1'b1;
              if (in_ready) begin
                fetch_nxt = fetch_r + CNT_W'(1);
              end
            end
          end
        end
      endcase
    end
  end

  // control decode from the next state, all outputs registered
  always_comb begin
    oe_n_nxt = 1'b1;
    ce_n_nxt = 1'b1;
    cs_n_nxt = 1'b1;
    wr_n_nxt = 1'b1;
    unique case (state_nxt)
      st_load: begin
        oe_n_nxt = 1'b0;
        ce_n_nxt = 1'b0;
        cs_n_nxt = 1'b0;
        wr_n_nxt = 1'b0;
      end
      st_pre_abort, st_abort: begin
        // memory off the shared data lines while the port resets
        oe_n_nxt = 1'b1;
        ce_n_nxt = 1'b1;
        cs_n_nxt = 1'b0;
        wr_n_nxt = 1'b1;
      end
      st_disable, st_hold, st_idle: begin
        oe_n_nxt = 1'b1;
        ce_n_nxt = 1'b1;
        cs_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
      end
    endcase
    clk_nxt = clk_r;
    if (clear_eff || state_nxt == st_idle || state_nxt == st_hold) begin
      clk_nxt = 1'b0;
    end else if (ce_eff) begin
      // high in the upper half of a live period, so at most sys/2^n
      clk_nxt = live_nxt && phase_nxt[DIV_LOG2-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= st_idle;
      phase_r <= '0;
      per_r <= '0;
      fetch_r <= '0;
      live_r <= 1'b0;
      addr_r <= '0;
      data_r <= '0;
      clk_r <= 1'b0;
      oe_n_r <= 1'b1;
      ce_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      per_r <= per_nxt;
      fetch_r <= fetch_nxt;
      live_r <= live_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      clk_r <= clk_nxt;
      oe_n_r <= oe_n_nxt;
      ce_n_r <= ce_n_nxt;
      cs_n_r <= cs_n_nxt;
      wr_n_r <= wr_n_nxt;
      done_r <= done_nxt;
    end
  end

  // outputs straight from flops
  assign mem_addr = addr_r;
  assign mem_out_en_n = oe_n_r;
  assign mem_chip_en_n = ce_n_r;
  assign cfg_port_select_n = cs_n_r;
  assign cfg_port_write_n = wr_n_r;
  assign cfg_clock = clk_r;
  assign cfg_data = data_r;
  assign scrub_state = state_r;
  assign scrub_done = done_r;

endmodule

`default_nettype wire

/* design/scrub_byte_buffer.sv */
`timescale 1ns/1ps
`default_nettype none

module scrub_byte_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic do_wr, do_rd;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  // pointer wrap written out so DEPTH need not be a power of two
  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (do_wr) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
    end
    if (do_rd) begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
    end
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + (PW+1)'(1);
    end else if (do_rd && !do_wr) begin
      cnt_nxt = cnt_r - (PW+1)'(1);
    end
    if (clr) begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end
  end

  // storage carries no reset, only the pointers and the count do
  always_ff @(posedge sys_clk) begin
    mem_r <= mem_nxt;
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

`default_nettype wire

/* design/scrub_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scrub_map.svh"

module scrub_interval_timer #(
  parameter int TW = 32,
  parameter logic [TW-1:0] INTERVAL = TW'(`SCRUB_INTERVAL_CYCLES)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic scrub_ce,
  output logic scrub_clear
);

  logic [TW-1:0] tick_r, tick_nxt;
  logic ce_r, ce_nxt;
  logic clear_r, clear_nxt;

  assign scrub_ce = ce_r;
  assign scrub_clear = clear_r;

  // terminal count restarts both counters with one synchronous clear
  always_comb begin
    tick_nxt = tick_r;
    ce_nxt = ce_r;
    clear_nxt = 1'b0;
    if (!run) begin
      tick_nxt = '0;
      ce_nxt = 1'b0;
    end else if (tick_r == INTERVAL - TW'(1)) begin
      tick_nxt = '0;
      clear_nxt = 1'b1;
      ce_nxt = 1'b1;
    end else begin
      tick_nxt = tick_r + TW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_r <= '0;
      ce_r <= 1'b0;
      clear_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      ce_r <= ce_nxt;
      clear_r <= clear_nxt;
    end
  end

endmodule

`default_nettype wire

/* design/scrub_map.svh */
`ifndef SCRUB_MAP_SVH
`define SCRUB_MAP_SVH

// clocking
`define SCRUB_SYS_CLK_MHZ 200
`define SCRUB_CFG_CLK_MAX_MHZ 50

// byte cycles of the load state per device size
`define SCRUB_LOAD_BYTES_SMALL 207972
`define SCRUB_LOAD_BYTES_MEDIUM 435312
`define SCRUB_LOAD_BYTES_LARGE 745596

// abort and disable state lengths in configuration clock cycles
`define SCRUB_ABORT_CYCLES 4
`define SCRUB_DISABLE_CYCLES 1

// widths
`define SCRUB_CNT_W_MIN 18
`define SCRUB_PORT_W 8
`define SCRUB_MEM_W 8

// interval timer, in system clock cycles (10 ms at 200 MHz)
`define SCRUB_INTERVAL_CYCLES 2000000

`endif

/* design/scrub_pkg.sv */
package scrub_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_pre_abort,
    st_load,
    st_abort,
    st_disable,
    st_hold
  } scrub_state_type;

endpackage

/* sim/config_memory_scrub_controller_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t %s", $time, m); end end

module config_memory_scrub_controller_test;
  import scrub_pkg::*;
  localparam int NB = 6;
  logic sys_clk, rst, scrub_ce, scrub_clear, auto_interval, lead_abort;
  logic clr, stall, oe_n, ce_n, cs_n, wr_n, cfg_clock, cfg_busy, scrub_done;
  logic [17:0] mem_addr;
  logic [7:0] mem_data, cfg_data;
  logic [7:0] bytes [0:15];
  scrub_state_type scrub_state;
  int byte_cnt, abort_clks, dis_clks;
  logic w_oe_n, w_ce_n, w_cs_n, w_wr_n, w_clk;
  logic [16:0] w_addr;
  logic [15:0] w_data;
  logic [7:0] w_port;
  logic [7:0] w_bytes [0:15];
  int w_cnt, w_abort, w_dis;
  int num_errors = 0;
  int check_count = 0;

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  config_memory_scrub_controller #(.LOAD_BYTES(18'h6), .INTERVAL(32'd120))
  i_dut (.sys_clk(sys_clk), .rst(rst), .scrub_ce(scrub_ce),
    .scrub_clear(scrub_clear), .auto_interval(auto_interval),
    .lead_abort(lead_abort), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_out_en_n(oe_n), .mem_chip_en_n(ce_n), .cfg_port_select_n(cs_n),
    .cfg_port_write_n(wr_n), .cfg_clock(cfg_clock), .cfg_data(cfg_data),
    .cfg_busy(cfg_busy), .scrub_state(scrub_state), .scrub_done(scrub_done));

  scrub_port_model i_far (.sys_clk(sys_clk), .clr(clr), .stall(stall),
    .mem_addr(mem_addr), .mem_out_en_n(oe_n), .mem_chip_en_n(ce_n),
    .cfg_port_select_n(cs_n), .cfg_port_write_n(wr_n), .cfg_clock(cfg_clock),
    .cfg_data(cfg_data), .mem_data(mem_data), .cfg_busy(cfg_busy),
    .byte_cnt(byte_cnt), .abort_clks(abort_clks), .dis_clks(dis_clks),
    .bytes(bytes));

  // 16-bit memory twin, same pacing; words split high lane first
  config_memory_scrub_controller #(.MEM_W(16), .LOAD_BYTES(18'h6),
    .INTERVAL(32'd120))
  i_dut_wide (.sys_clk(sys_clk), .rst(rst), .scrub_ce(scrub_ce),
    .scrub_clear(scrub_clear), .auto_interval(auto_interval),
    .lead_abort(lead_abort), .mem_addr(w_addr), .mem_data(w_data),
    .mem_out_en_n(w_oe_n), .mem_chip_en_n(w_ce_n),
    .cfg_port_select_n(w_cs_n), .cfg_port_write_n(w_wr_n),
    .cfg_clock(w_clk), .cfg_data(w_port), .cfg_busy(cfg_busy),
    .scrub_state(), .scrub_done());

  // wide memory content: high lane is the word index, low lane its inverse
  assign w_data = {w_addr[7:0], ~w_addr[7:0]};

  scrub_port_model i_far_wide (.sys_clk(sys_clk), .clr(clr), .stall(stall),
    .mem_addr({1'b0, w_addr}), .mem_out_en_n(w_oe_n), .mem_chip_en_n(w_ce_n),
    .cfg_port_select_n(w_cs_n), .cfg_port_write_n(w_wr_n), .cfg_clock(w_clk),
    .cfg_data(w_port), .mem_data(), .cfg_busy(), .byte_cnt(w_cnt),
    .abort_clks(w_abort), .dis_clks(w_dis), .bytes(w_bytes));

  task end_sim;
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // bounded wait for the completion pulse
  task wait_done;
    for (int i = 0; i < 600; i++) begin
      @(negedge sys_clk);
      if (scrub_done === 1'b1) return;
    end
    num_errors++;
    $display("BAD %0t scrub never finished", $time);
    end_sim();
  endtask

  task check_bytes(input int ab);
    `CHK(byte_cnt, NB, "byte count")
    for (int i = 0; i < NB; i++) begin
      `CHK(bytes[i], 8'(i) ^ 8'h3c, "byte value")
    end
    `CHK(abort_clks, ab, "abort clocks")
    `CHK(dis_clks, 1, "disable clocks")
    `CHK(w_cnt, NB, "wide byte count")
    for (int i = 0; i < NB; i++) begin
      `CHK(w_bytes[i], 8'(i / 2) ^ {8{i[0]}}, "wide byte")
    end
    `CHK(w_abort, ab, "wide abort clocks")
    `CHK(w_dis, 1, "wide disable clocks")
  endtask

  // host clears the counter, then raises count enable
  task start(input logic lead);
    @(negedge sys_clk);
    clr = 1'b1;
    scrub_clear = 1'b1;
    lead_abort = lead;
    @(negedge sys_clk);
    clr = 1'b0;
    scrub_clear = 1'b0;
    scrub_ce = 1'b1;
  endtask

  task t_plain(input logic lead);
    start(lead);
    wait_done();
    check_bytes(lead ? 8 : 4);
  endtask

  task t_hold;
    logic [17:0] a;
    a = mem_addr;
    repeat (30) @(negedge sys_clk);
    `CHK(mem_addr, a, "hold address")
    `CHK({oe_n, ce_n, cs_n, wr_n}, 4'hf, "hold controls")
    `CHK(scrub_state, st_hold, "hold state")
    `CHK(dis_clks, 1, "no clocks in hold")
  endtask

  // port stalls mid-load; buffer must lose no byte
  task t_stall;
    start(1'b0);
    for (int i = 0; i < 200 && byte_cnt < 2; i++) @(negedge sys_clk);
    if (byte_cnt < 2) begin
      num_errors++;
      $display("BAD %0t stall point never reached", $time);
      end_sim();
    end
    stall = 1'b1;
    repeat (40) @(negedge sys_clk);
    `CHK(byte_cnt, 2, "stall blocks bytes")
    stall = 1'b0;
    wait_done();
    check_bytes(4);
  endtask

  task t_pause;
    logic [17:0] a;
    int b;
    start(1'b0);
    repeat (12) @(negedge sys_clk);
    scrub_ce = 1'b0;
    a = mem_addr;
    // a port clock raised just before the pause is still counted once
    @(negedge sys_clk);
    b = byte_cnt;
    repeat (19) @(negedge sys_clk);
    `CHK(mem_addr, a, "paused address")
    `CHK(byte_cnt, b, "paused bytes")
    scrub_ce = 1'b1;
    wait_done();
    check_bytes(4);
  endtask

  // interval timer paces two scrubs on its own
  task t_auto;
    @(negedge sys_clk);
    scrub_ce = 1'b0;
    clr = 1'b1;
    // interval kept short here; a real system scrubs ~10x per upset
    auto_interval = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    wait_done();
    wait_done();
    `CHK(byte_cnt, 2 * NB, "auto byte count")
    `CHK(dis_clks, 2, "auto disable clocks")
    `CHK(bytes[NB], 8'h3c, "second scrub from zero")
    auto_interval = 1'b0;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    scrub_ce = 1'b0;
    scrub_clear = 1'b0;
    auto_interval = 1'b0;
    lead_abort = 1'b0;
    clr = 1'b1;
    stall = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    clr = 1'b0;
    `CHK(scrub_state, st_idle, "reset state")
    `CHK({oe_n, ce_n, cs_n, wr_n, cfg_clock}, 5'h1e, "reset pins")
    `CHK(mem_addr, 18'h0, "reset address")
    t_plain(1'b0);
    t_hold();
    t_plain(1'b1);
    t_stall();
    t_pause();
    t_auto();
    end_sim();
  end
endmodule

`default_nettype wire

/* sim/scrub_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module scrub_checker
  import scrub_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scrub_clear,
  input wire logic auto_interval,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_out_en_n,
  input wire logic mem_chip_en_n,
  input wire logic cfg_port_select_n,
  input wire logic cfg_port_write_n,
  input wire logic cfg_clock,
  input wire logic [7:0] cfg_data,
  input var scrub_pkg::scrub_state_type scrub_state
);
  logic [2:0] abort_clks_r;
  logic clk_q_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // port clock rises seen in the abort state, cleared outside it
  always_ff @(posedge sys_clk) begin
    clk_q_r <= cfg_clock;
    if (rst || scrub_state != st_abort) begin
      abort_clks_r <= 3'h0;
    end else if (cfg_clock && !clk_q_r) begin
      abort_clks_r <= abort_clks_r + 3'h1;
    end
  end

  chk_load_all_low: assert property (scrub_state == st_load |->
    !mem_out_en_n && !cfg_port_select_n && !cfg_port_write_n)
    else $error("load state controls not low");
  chk_abort_levels: assert property (scrub_state == st_abort |->
    mem_out_en_n && !cfg_port_select_n && cfg_port_write_n)
    else $error("abort state controls wrong");
  chk_disable_high: assert property (scrub_state == st_disable |->
    mem_out_en_n && cfg_port_select_n && cfg_port_write_n)
    else $error("disable state controls not high");
  chk_enables_same: assert property (
    mem_out_en_n == mem_chip_en_n)
    else $error("memory enables differ");
  chk_abort_length: assert property (
    $rose(scrub_state == st_disable) |-> abort_clks_r == 3'h4)
    else $error("abort did not last four port clocks");
  chk_load_origin: assert property (
    $rose(scrub_state == st_load) |-> mem_addr == '0)
    else $error("load did not start at address zero");
  chk_hold_quiet: assert property (scrub_state == st_hold |->
    mem_out_en_n && cfg_port_select_n && cfg_port_write_n && !cfg_clock)
    else $error("hold state not quiet");
  chk_hold_addr: assert property (
    scrub_state == st_hold && !scrub_clear && !auto_interval
    |=> $stable(mem_addr))
    else $error("address moved in hold");
  chk_clock_rate: assert property ($rose(cfg_clock) |->
    ##1 (!$rose(cfg_clock)) [*3])
    else $error("port clock faster than a quarter");
  chk_data_steady: assert property (
    cfg_clock && $past(cfg_clock) |-> $stable(cfg_data))
    else $error("port data changed while clock high");
  chk_hold_order: assert property (
    $rose(scrub_state == st_hold) |-> $past(scrub_state) == st_disable)
    else $error("hold not entered from disable");
endmodule

bind config_memory_scrub_controller scrub_checker #(.ADDR_W(ADDR_W)) u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .scrub_clear(scrub_clear),
  .auto_interval(auto_interval),
  .mem_addr(mem_addr),
  .mem_out_en_n(mem_out_en_n),
  .mem_chip_en_n(mem_chip_en_n),
  .cfg_port_select_n(cfg_port_select_n),
  .cfg_port_write_n(cfg_port_write_n),
  .cfg_clock(cfg_clock),
  .cfg_data(cfg_data),
  .scrub_state(scrub_state)
);

`default_nettype wire

/* sim/scrub_port_model.sv */
`timescale 1ns/1ps
`default_nettype none

module scrub_port_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic stall,
  input wire logic [17:0] mem_addr,
  input wire logic mem_out_en_n,
  input wire logic mem_chip_en_n,
  input wire logic cfg_port_select_n,
  input wire logic cfg_port_write_n,
  input wire logic cfg_clock,
  input wire logic [7:0] cfg_data,
  output logic [7:0] mem_data,
  output logic cfg_busy,
  output int byte_cnt,
  output int abort_clks,
  output int dis_clks,
  output logic [7:0] bytes [0:15]
);
  logic [7:0] last = 8'h00;
  logic clk_q = 1'b0;

  // released bus shows the inverse of its last value, not a stale copy
  assign mem_data = (!mem_out_en_n && !mem_chip_en_n) ?
    (mem_addr[7:0] ^ 8'h3c) : ~last;
  assign cfg_busy = stall;

  // port side: classify each port clock rise by select and write
  always @(posedge sys_clk) begin
    clk_q <= cfg_clock;
    if (!mem_out_en_n) last <= mem_data;
    if (clr) begin
      byte_cnt <= 0;
      abort_clks <= 0;
      dis_clks <= 0;
    end else if (cfg_clock && !clk_q) begin
      if (!cfg_port_select_n && !cfg_port_write_n) begin
        if (byte_cnt < 16) bytes[byte_cnt] <= cfg_data;
        byte_cnt <= byte_cnt + 1;
      end else if (!cfg_port_select_n) begin
        abort_clks <= abort_clks + 1;
      end else begin
        dis_clks <= dis_clks + 1;
      end
    end
  end
endmodule

`default_nettype wire
